//--- logic/rng_pkg.sv
// Purpose: shared constants and types of the random number generator
// Assumes: core clock of 40 MHz, 32-kHz low-power tick derived from it
// Notes: register offsets are byte addresses on the plain register port
package rng_pkg;
    // clocking and timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned LP_HZ = 32_768;
    // 32-kHz enable divider, rounded down to whole core cycles
    localparam int unsigned LP_DIV_CYCLES = CLK_HZ / LP_HZ;
    localparam int unsigned SAMPLE_PERIOD_US = 256;
    // longest time, rounded down; exact at 40 MHz (10240 cycles)
    localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);

    // widths
    localparam int unsigned VALUE_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_VALUE = 8'h08;
    localparam logic [7:0] OFS_INT_STATUS = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;

    // control field positions
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_STOP_BIT = 1;
    localparam int unsigned CTRL_CONT_BIT = 2;
    localparam int unsigned CTRL_IE_BIT = 3;
    // status field positions
    localparam int unsigned STAT_RUN_BIT = 0;
    localparam int unsigned STAT_READY_BIT = 1;
    localparam int unsigned STAT_CONT_BIT = 2;
    // interrupt field position
    localparam int unsigned INT_READY_BIT = 0;

    // reset values
    localparam logic [15:0] RST_VALUE = 16'h0000;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;

    typedef enum logic [1:0] {
        RNG_IDLE = 2'b00,
        RNG_RUN = 2'b01
    } rng_state_t;
endpackage

//--- logic/rng_if.sv
// Purpose: carrier between the control logic and the entropy register
// Assumes: single core clock
// Notes: value is combinational from the generator register
`timescale 1ns/1ps
interface rng_if #(parameter int unsigned W = 16);
    logic step;
    logic mix;
    logic noise;
    logic [W-1:0] value;
    modport gen (input step, input mix, input noise, output value);
    modport ctl (output step, output mix, output noise, input value);
endinterface

//--- logic/rng_lfsr.sv
// Purpose: galois shift register with noise folded in on the slow tick
// Assumes: noise input synchronous to core_clk
// Notes: the zero state is escaped by reloading the seed
`timescale 1ns/1ps
module rng_lfsr
    import rng_pkg::*;
#(
    parameter int unsigned W = 16
) (
    input wire logic core_clk, // core clock
    input wire logic rst,      // synchronous reset, active high
    rng_if.gen gen             // step, mix, noise in; value out
);
    logic [W-1:0] lfsr;
    logic [W-1:0] next_lfsr;

    // shift while stepping, fold noise on each 32-kHz tick
    always_comb begin
        next_lfsr = lfsr;
        if (gen.step) begin
            next_lfsr = {1'b0, lfsr[W-1:1]};
            if (lfsr[0]) begin
                next_lfsr = next_lfsr ^ LFSR_TAPS[W-1:0];
            end
        end
        if (gen.mix) begin
            next_lfsr[0] = next_lfsr[0] ^ gen.noise;
        end
        // all-zero would lock up the register
        if (next_lfsr == '0) begin
            next_lfsr = LFSR_SEED[W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lfsr <= LFSR_SEED[W-1:0];
        end else begin
            lfsr <= next_lfsr;
        end
    end

    assign gen.value = lfsr;
endmodule

//--- logic/rng_top.sv
// Purpose: random number generator with single-shot and continuous modes
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: entropy quality rests on noise_in jitter against the 32-kHz tick
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Each result is a 16-bit value that software reads from the value register.
// [RULE2] A single-shot start yields exactly one value and then the generator halts itself.
// [RULE3] A continuous start keeps running and delivers a fresh value every 256 us.
// [RULE4] One start command launches either mode and may also set the ready interrupt enable.
// [RULE5] With the interrupt enabled, each new value raises the system controller interrupt.
// [RULE6] The latest value stays readable after generation completes.
// [RULE7] A pollable ready flag tells software that a new value is waiting.
// [RULE8] A stop command ends continuous production of values.
// [RULE9] The generator is paced from the 32-kHz low-power domain; the code counts core cycles and uses the tick only for noise.
// [RULE10] Reading the value clears the ready flag so the next flag means a fresh value.
module rng_top
    import rng_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES,
    parameter int unsigned LP_DIV = LP_DIV_CYCLES,
    parameter int unsigned VALUE_WIDTH = VALUE_W
) (
    input wire logic core_clk,                 // core clock, 40 MHz
    input wire logic rst,                      // synchronous reset, active high
    input wire logic [ADDR_W-1:0] addr,        // register byte address
    input wire logic [DATA_W-1:0] wr_data,     // write data
    input wire logic wr_en,                    // write strobe
    input wire logic rd_en,                    // read strobe
    output logic [DATA_W-1:0] rd_data,         // read data, cycle after rd_en
    input wire logic noise_in,                 // raw noise bit
    output logic sysctrl_irq                   // level interrupt to system controller
);
    localparam int unsigned CNT_W = $clog2(SAMPLE_CYC + 1);
    localparam int unsigned DIV_W = $clog2(LP_DIV + 1);

    // register map, byte offsets on the plain port:
    //   control at OFS_CTRL: start, stop, continuous, interrupt enable
    //   status at OFS_STATUS: running, ready, continuous
    //   value at OFS_VALUE: last result in the low half word
    //   event at OFS_INT_STATUS, write one to clear; mask at OFS_INT_MASK
    // unmapped offsets read zero and ignore writes, so software never stalls

    // register decode
    logic ctrl_wr;
    logic start_cmd;
    logic stop_cmd;
    logic value_rd;
    logic int_status_wr;
    logic int_mask_wr;

    // 32-kHz tick divider
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] next_div_cnt;
    logic lp_tick;
    logic next_lp_tick;

    // sequencing
    rng_state_t state;
    rng_state_t next_state;
    logic cont_mode;
    logic next_cont_mode;
    logic [CNT_W-1:0] period_cnt;
    logic [CNT_W-1:0] next_period_cnt;
    logic done;
    logic next_done;

    // result and flags
    logic [VALUE_WIDTH-1:0] value_q;
    logic [VALUE_WIDTH-1:0] next_value_q;
    logic ready;
    logic next_ready;
    logic int_status;
    logic next_int_status;
    logic int_mask;
    logic next_int_mask;
    logic next_irq;

    // read path
    logic [DATA_W-1:0] next_rd_data;

    // generator register lives in its own module, reached through the carrier
    rng_if #(.W(VALUE_WIDTH)) gen_bus ();

    rng_lfsr #(
        .W(VALUE_WIDTH)
    ) u_lfsr (
        .core_clk(core_clk),
        .rst(rst),
        .gen(gen_bus.gen)
    );

    // strobes qualified by address; a start and stop together start
    always_comb begin
        ctrl_wr = wr_en && (addr == OFS_CTRL);
        // [RULE4] start command decode
        start_cmd = ctrl_wr && wr_data[CTRL_START_BIT];
        // [RULE8] stop command decode
        stop_cmd = ctrl_wr && wr_data[CTRL_STOP_BIT] && !wr_data[CTRL_START_BIT];
        value_rd = rd_en && (addr == OFS_VALUE);
        int_status_wr = wr_en && (addr == OFS_INT_STATUS);
        int_mask_wr = wr_en && (addr == OFS_INT_MASK);
    end

    // [RULE9] low-power tick divider
    // one-cycle enable stands in for the 32-kHz clock; keeps a single domain
    // the divider free-runs from reset; its phase against a start command
    // is arbitrary, which only moves where noise lands, not the period
    always_comb begin
        next_div_cnt = div_cnt;
        next_lp_tick = 1'b0;
        if (div_cnt == DIV_W'(LP_DIV - 1)) begin
            next_div_cnt = '0;
            next_lp_tick = 1'b1;
        end else begin
            next_div_cnt = div_cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_cnt <= '0;
            lp_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            lp_tick <= next_lp_tick;
        end
    end

    // generator steps only while running; when halted the divider still runs and noise still folds in on each tick
    // [RULE9] noise folded on the slow tick
    assign gen_bus.step = (state == RNG_RUN);
    assign gen_bus.mix = lp_tick;
    assign gen_bus.noise = noise_in;
    // noise only helps if it jitters against the tick; a clean or
    // tick-locked source leaves the register on a fixed sequence,
    // so the low-power clock must not be a precise external one

    // sequencer: period counted in core cycles so the 256 us figure is exact
    // timing of one value: the start edge loads the counter with zero, the
    // counter reaches SAMPLE_CYC-1 after that many edges, done registers on
    // the next edge and the result lands one edge later
    // limitation: a stop in single-shot mode aborts the shot and no value
    // is delivered; software sees ready stay low
    always_comb begin
        next_state = state;
        next_cont_mode = cont_mode;
        next_period_cnt = period_cnt;
        next_done = 1'b0;
        case (state)
            RNG_IDLE: begin
                // [RULE4] launch in chosen mode
                if (start_cmd) begin
                    next_state = RNG_RUN;
                    next_cont_mode = wr_data[CTRL_CONT_BIT];
                    next_period_cnt = '0;
                end
            end
            RNG_RUN: begin
                if (start_cmd) begin
                    // restart discards the partial period
                    next_cont_mode = wr_data[CTRL_CONT_BIT];
                    next_period_cnt = '0;
                end else if (stop_cmd) begin
                    // [RULE8] stop halts production
                    next_state = RNG_IDLE;
                    next_period_cnt = '0;
                end else if (period_cnt == CNT_W'(SAMPLE_CYC - 1)) begin
                    // [RULE3] value every period
                    next_done = 1'b1;
                    next_period_cnt = '0;
                    // [RULE2] single shot halts itself
                    if (!cont_mode) begin
                        next_state = RNG_IDLE;
                    end
                end else begin
                    next_period_cnt = period_cnt + CNT_W'(1);
                end
            end
            default: begin
                next_state = RNG_IDLE;
                next_period_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= RNG_IDLE;
            cont_mode <= 1'b0;
            period_cnt <= '0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            cont_mode <= next_cont_mode;
            period_cnt <= next_period_cnt;
            done <= next_done;
        end
    end

    // result capture and ready flag
    // the value is held, not re-read from the generator, so software may
    // read it late and still get the result that raised ready
    always_comb begin
        next_value_q = value_q;
        next_ready = ready;
        // [RULE10] read clears ready
        if (value_rd) begin
            next_ready = 1'b0;
        end
        if (done) begin
            // [RULE6] hold latest value
            // [RULE1] 16-bit result
            next_value_q = gen_bus.value;
            // [RULE7] ready flag, set beats clear
            next_ready = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            value_q <= RST_VALUE[VALUE_WIDTH-1:0];
            ready <= 1'b0;
        end else begin
            value_q <= next_value_q;
            ready <= next_ready;
        end
    end

    // sticky interrupt status, mask and registered output
    // a start command rewrites the mask bit, so an enable set earlier by a
    // mask write is dropped unless the start command carries it again
    always_comb begin
        next_int_status = int_status;
        next_int_mask = int_mask;
        if (int_status_wr && wr_data[INT_READY_BIT]) begin
            next_int_status = 1'b0;
        end
        // [RULE5] event sets sticky bit
        // set placed last so an event in the clear cycle survives
        if (done) begin
            next_int_status = 1'b1;
        end
        if (int_mask_wr) begin
            next_int_mask = wr_data[INT_READY_BIT];
        end
        // [RULE4] start sets enable
        if (start_cmd) begin
            next_int_mask = wr_data[CTRL_IE_BIT];
        end
        // [RULE5] masked interrupt level
        next_irq = next_int_status && next_int_mask;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_status <= 1'b0;
            int_mask <= 1'b0;
            sysctrl_irq <= 1'b0;
        end else begin
            int_status <= next_int_status;
            int_mask <= next_int_mask;
            sysctrl_irq <= next_irq;
        end
    end

    // read mux; unmapped addresses and idle cycles return zero
    // registered read data costs one cycle of latency but keeps the output
    // straight from a flip-flop; the mux is zero outside read cycles so the
    // port idles at zero between accesses
    always_comb begin
        next_rd_data = '0;
        if (rd_en) begin
            case (addr)
                OFS_CTRL: begin
                    next_rd_data[CTRL_CONT_BIT] = cont_mode;
                    next_rd_data[CTRL_IE_BIT] = int_mask;
                end
                OFS_STATUS: begin
                    next_rd_data[STAT_RUN_BIT] = (state == RNG_RUN);
                    // [RULE7] pollable ready
                    next_rd_data[STAT_READY_BIT] = ready;
                    next_rd_data[STAT_CONT_BIT] = cont_mode;
                end
                OFS_VALUE: begin
                    // [RULE1] value in low bits
                    next_rd_data[VALUE_WIDTH-1:0] = value_q;
                end
                OFS_INT_STATUS: begin
                    next_rd_data[INT_READY_BIT] = int_status;
                end
                OFS_INT_MASK: begin
                    next_rd_data[INT_READY_BIT] = int_mask;
                end
                default: begin
                    next_rd_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd_data;
        end
    end
endmodule

//--- test/rng_asserts.sv
// Purpose: port checks of the random number generator
// Assumes: bound onto rng_top, one clock
// Notes: status checks need a read right after the write
`timescale 1ns/1ps
module rng_asserts
    import rng_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic rst, // sync reset
    input wire logic [ADDR_W-1:0] addr, // byte address
    input wire logic [DATA_W-1:0] wr_data, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    input wire logic [DATA_W-1:0] rd_data, // read data
    input wire logic noise_in, // noise bit
    input wire logic sysctrl_irq // interrupt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // bus steps shared by the checks
    sequence s_start;
        wr_en && addr == OFS_CTRL && wr_data[CTRL_START_BIT];
    endsequence
    sequence s_stop;
        wr_en && addr == OFS_CTRL && wr_data[CTRL_STOP_BIT] && !wr_data[CTRL_START_BIT];
    endsequence
    sequence s_rd(logic [ADDR_W-1:0] a);
        rd_en && addr == a;
    endsequence
    // read port answers only the cycle after a strobe
    chk_rd_idle_zero: assert property (
        !$past(rd_en) |-> rd_data == 32'h0) else $error("read data not idle");
    chk_value_width: assert property (
        s_rd(OFS_VALUE) |=> rd_data[31:16] == 16'h0) else $error("value too wide");
    chk_unmapped_zero: assert property (
        rd_en && addr > OFS_INT_MASK |=> rd_data == 32'h0) else $error("unmapped read");
    // mask off silences the line within two cycles
    chk_mask_silences: assert property (
        wr_en && addr == OFS_INT_MASK && !wr_data[INT_READY_BIT] |-> ##[1:2] !sysctrl_irq)
        else $error("irq despite mask");
    chk_mask_readback: assert property (
        wr_en && addr == OFS_INT_MASK ##1 s_rd(OFS_INT_MASK)
        |=> rd_data == {31'h0, $past(wr_data[INT_READY_BIT], 2)}) else $error("mask read");
    // start runs in the chosen mode, stop halts
    chk_start_runs: assert property (
        s_start ##1 s_rd(OFS_STATUS) |=> rd_data[STAT_RUN_BIT]
        && rd_data[STAT_CONT_BIT] == $past(wr_data[CTRL_CONT_BIT], 2)) else $error("start");
    chk_ctrl_readback: assert property (
        s_start ##1 s_rd(OFS_STATUS) ##1 s_rd(OFS_CTRL)
        |=> rd_data == {28'h0, $past(wr_data[CTRL_IE_BIT:CTRL_CONT_BIT], 3), 2'h0})
        else $error("control read");
    chk_stop_halts: assert property (
        s_stop ##1 s_rd(OFS_STATUS) |=> !rd_data[STAT_RUN_BIT]) else $error("stop ignored");
endmodule

//--- test/tb_top.sv
// Purpose: self-checking bench of the random number generator
// Assumes: short period and divider keep the run brief
// Notes: values are random, so checks look at flags, timing and stability
`timescale 1ns/1ps
module tb_top
    import rng_pkg::*;
;
    localparam int unsigned SC = 16; // shortened sample period
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic noise_in = 1'b0;
    logic [31:0] rd_data;
    logic sysctrl_irq;
    logic [31:0] got;
    logic [31:0] v1;
    logic [31:0] c;
    logic [7:0] regs [6] = '{OFS_CTRL, OFS_STATUS, OFS_VALUE, OFS_INT_STATUS, OFS_INT_MASK, 8'h14};
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int kk;
    time t0;
    rng_top #(.SAMPLE_CYC(SC), .LP_DIV(4)) DUT (.core_clk(core_clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .noise_in(noise_in), .sysctrl_irq(sysctrl_irq));
    // clock and hang guard
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end
    // one cycle, fresh noise every edge
    task automatic step();
        @(posedge core_clk);
        noise_in <= 1'($urandom);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        step();
    endtask
    // strobe stays up until the next task lowers it
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        step();
        got = rd_data;
    endtask
    task automatic idle(input int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) step();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(got, exp);
    endtask
    // bounded wait for the interrupt line
    task automatic wait_irq();
        kk = 0;
        while (sysctrl_irq !== 1'b1 && kk < 4 * SC) begin
            idle(1);
            kk++;
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // status word built from its three flags
    function automatic logic [31:0] exp_status(input logic run, input logic rdy,
        input logic cont);
        logic [31:0] r;
        r = 32'h0;
        r[STAT_RUN_BIT] = run;
        r[STAT_READY_BIT] = rdy;
        r[STAT_CONT_BIT] = cont;
        return r;
    endfunction
    // main sequence
    initial begin
        void'($urandom(32'h0E71));
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        step();
        foreach (regs[i]) rdc(regs[i], 32'h0);
        wr(8'hFC, 32'hFFFFFFFF);
        rdc(8'hFC, 32'h0);
        chk({31'h0, sysctrl_irq}, 32'h0);
        $display("test reset done");
        wr(OFS_CTRL, 32'h9);
        rdc(OFS_STATUS, exp_status(1'b1, 1'b0, 1'b0));
        wait_irq();
        chk(kk, SC);
        rdc(OFS_STATUS, exp_status(1'b0, 1'b1, 1'b0));
        rd(OFS_VALUE);
        v1 = got;
        chk(v1 & 32'hFFFF0000, 32'h0);
        rdc(OFS_VALUE, v1);
        rdc(OFS_STATUS, exp_status(1'b0, 1'b0, 1'b0));
        idle(3 * SC);
        rdc(OFS_VALUE, v1);
        rdc(OFS_INT_STATUS, 32'h1);
        wr(OFS_INT_MASK, 32'h0);
        rdc(OFS_INT_MASK, 32'h0);
        idle(1);
        chk({31'h0, sysctrl_irq}, 32'h0);
        wr(OFS_INT_MASK, 32'h1);
        idle(2);
        chk({31'h0, sysctrl_irq}, 32'h1);
        wr(OFS_INT_STATUS, 32'h1);
        idle(2);
        chk({31'h0, sysctrl_irq}, 32'h0);
        $display("test single done");
        // continuous without interrupt, then the period
        wr(OFS_CTRL, 32'h5);
        rdc(OFS_STATUS, exp_status(1'b1, 1'b0, 1'b1));
        rdc(OFS_CTRL, 32'h4);
        idle(SC);
        chk({31'h0, sysctrl_irq}, 32'h0);
        rdc(OFS_INT_STATUS, 32'h1);
        wr(OFS_INT_STATUS, 32'h1);
        wr(OFS_INT_MASK, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wait_irq();
            if (i > 0) chk(32'(($time - t0) / 25), SC);
            t0 = $time;
            rdc(OFS_STATUS, exp_status(1'b1, 1'b1, 1'b1));
            rd(OFS_VALUE);
            wr(OFS_INT_STATUS, 32'h1);
            idle(2);
        end
        wr(OFS_CTRL, 32'h2);
        rd(OFS_STATUS);
        chk(got & 32'h1, 32'h0);
        idle(3 * SC);
        rdc(OFS_INT_STATUS, 32'h0);
        $display("test continuous done");
        // restart half way: the period counts from the second start
        wr(OFS_CTRL, 32'hD);
        idle(SC / 2);
        wr(OFS_CTRL, 32'h9);
        rdc(OFS_CTRL, 32'h8);
        wait_irq();
        chk(kk, SC);
        rdc(OFS_STATUS, exp_status(1'b0, 1'b1, 1'b0));
        // stop aborts a single shot: no value, no event
        rd(OFS_VALUE);
        wr(OFS_INT_STATUS, 32'h1);
        wr(OFS_CTRL, 32'h1);
        idle(SC / 2);
        wr(OFS_CTRL, 32'h2);
        idle(2 * SC);
        rdc(OFS_INT_STATUS, 32'h0);
        rdc(OFS_STATUS, exp_status(1'b0, 1'b0, 1'b0));
        $display("test restart done");
        // random mode, enable and stop bit; start wins over stop
        repeat (6) begin
            c = 32'h1 | ($urandom & 32'hE);
            wr(OFS_CTRL, c);
            rdc(OFS_STATUS, exp_status(1'b1, 1'b0, c[2]));
            rdc(OFS_CTRL, c & 32'hC);
            idle(SC);
            rdc(OFS_STATUS, exp_status(c[2], 1'b1, c[2]));
            chk({31'h0, sysctrl_irq}, {31'h0, c[3]});
            rd(OFS_VALUE);
            rdc(8'h14 + 8'($urandom % 236), 32'h0);
            wr(OFS_CTRL, 32'h2);
            wr(OFS_INT_STATUS, 32'h1);
            idle(2);
            chk({31'h0, sysctrl_irq}, 32'h0);
        end
        $display("test random done");
        // reset in mid-run with the line high and a value waiting
        wr(OFS_CTRL, 32'hD);
        idle(SC + 2);
        chk({31'h0, sysctrl_irq}, 32'h1);
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
        idle(1);
        chk({31'h0, sysctrl_irq}, 32'h0);
        foreach (regs[i]) rdc(regs[i], 32'h0);
        $display("test reset again done");
        close_out();
    end
endmodule
bind rng_top rng_asserts u_chk (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .noise_in(noise_in), .sysctrl_irq(sysctrl_irq));
